/* File: src/vr_fault_supervisor.sv */
// fault supervisor: qualifies comparator flags, latches faults, drives
// gate control and power good, decodes the start-up strap
// assumes comparator and strap levels arrive asynchronously from analog
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module vr_fault_supervisor import vr_fault_pkg::*; #(
    parameter int unsigned OC_QUAL_CYC = OC_QUAL_CYC_DEF,
    parameter int unsigned VQUAL_CYC = VQUAL_CYC_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic regulator_enable_input,
    input wire logic supply_por_ok,
    input wire cmp_t cmp_in,
    input wire logic [2:0] strap_class,
    input wire logic soft_start_done,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    output logic irq,
    output gate_t gate,
    output logic power_good_output,
    output logic soft_start_req,
    output strap_cfg_t strap_cfg
);
    // ==========================================
    // state
    typedef struct packed {
        pins_t s1;
        pins_t s2;
        sup_state_t st;
        logic [TMR_W-1:0] oc_cnt;
        logic [TMR_W-1:0] uv_cnt;
        logic [TMR_W-1:0] ov1_cnt;
        flt_t flt;
        logic dis;
        logic strap_vld;
        logic [2:0] strap_cls;
        strap_cfg_t cfg;
        logic [5:0] status;
        logic [5:0] mask;
        logic run_allow;
        logic [DW-1:0] rdata;
        logic ss_pulse;
        logic pwr_good;
        gate_t gate;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // class 0 is the unfitted strap; bits 1:0 pick 60, 68, 62 or 54 uA, bit 2 sets osr_en
    function automatic strap_cfg_t strap_decode(input logic [2:0] cls);
        strap_cfg_t c;
        c.osr_en = cls[2];
        case (cls[1:0])
            2'h0: c.oc_ua = OC_UA_60;
            2'h1: c.oc_ua = OC_UA_68;
            2'h2: c.oc_ua = OC_UA_62;
            default: c.oc_ua = OC_UA_54;
        endcase
        if (cls == 3'h0) begin
            c.osr_en = 1'b0;
        end
        return c;
    endfunction : strap_decode

    // saturating qualification timer, zeroed when the condition drops
    function automatic logic [TMR_W-1:0] qual_tick(input logic cond,
            input logic [TMR_W-1:0] cnt, input logic [TMR_W-1:0] lim);
        if (!cond) begin
            return '0;
        end
        return (cnt == lim) ? cnt : cnt + TMR_W'(1);
    endfunction : qual_tick

    localparam logic [TMR_W-1:0] OC_LIM = TMR_W'(OC_QUAL_CYC - 1);
    localparam logic [TMR_W-1:0] V_LIM = TMR_W'(VQUAL_CYC - 1);

    logic enabled;
    logic active;
    logic [5:0] ev;

    // ==========================================
    // next state
    always_comb begin
        s_nxt = s_r;
        ev = '0;
        s_nxt.s1 = '{en: regulator_enable_input, por_ok: supply_por_ok,
                     cmp: cmp_in, strap: strap_class};
        s_nxt.s2 = s_r.s1;
        s_nxt.ss_pulse = 1'b0;
        enabled = s_r.s2.en && s_r.s2.por_ok;
        active = (s_r.st == S_SOFT) || (s_r.st == S_RUN);

        // timers only run while the modulator is live
        s_nxt.oc_cnt = qual_tick(active && s_r.s2.cmp.oc,
                                 s_r.oc_cnt, OC_LIM);
        s_nxt.uv_cnt = qual_tick(active && s_r.s2.cmp.uv,
                                 s_r.uv_cnt, V_LIM);
        s_nxt.ov1_cnt = qual_tick(active && s_r.s2.cmp.ov1,
                                  s_r.ov1_cnt, V_LIM);
        if (active && s_r.s2.cmp.oc && s_r.oc_cnt == OC_LIM) begin
            s_nxt.flt.oc = 1'b1;
            ev[0] = 1'b1;
        end
        if (active && s_r.s2.cmp.woc) begin
            s_nxt.flt.woc = 1'b1;
            ev[1] = 1'b1;
        end
        if (active && s_r.s2.cmp.uv && s_r.uv_cnt == V_LIM) begin
            s_nxt.flt.uv = 1'b1;
            ev[2] = 1'b1;
        end
        if (active && s_r.s2.cmp.ov1 && s_r.ov1_cnt == V_LIM) begin
            s_nxt.flt.ov1 = 1'b1;
            ev[3] = 1'b1;
        end

        // absolute overvoltage watched regardless of other faults
        if (enabled && s_r.s2.cmp.ov2_hi) begin
            s_nxt.flt.ov2 = 1'b1;
            s_nxt.dis = 1'b1;
            ev[4] = !s_r.dis;
        end else if (!enabled || s_r.s2.cmp.ov2_lo) begin
            s_nxt.dis = 1'b0;
        end

        case (s_r.st)
            S_OFF: begin
                if (enabled && s_r.run_allow && s_r.flt == '0) begin
                    s_nxt.st = S_SOFT;
                    s_nxt.ss_pulse = 1'b1;
                    // a software restart keeps the strap held
                    if (!s_r.strap_vld) begin
                        s_nxt.strap_vld = 1'b1;
                        s_nxt.strap_cls = s_r.s2.strap;
                        s_nxt.cfg = strap_decode(s_r.s2.strap);
                    end
                    ev[5] = 1'b1;
                end
            end
            S_SOFT: begin
                if (soft_start_done) begin
                    s_nxt.st = S_RUN;
                end
            end
            S_RUN: begin
                if (!s_r.run_allow) begin
                    s_nxt.st = S_OFF;
                end
            end
            S_FAULT: begin
            end
            default: s_nxt.st = S_OFF;
        endcase
        if (s_nxt.flt != '0) begin
            s_nxt.st = S_FAULT;
        end

        // enable low discards strap and the four ordinary faults
        if (!s_r.s2.en) begin
            s_nxt.flt.oc = 1'b0;
            s_nxt.flt.woc = 1'b0;
            s_nxt.flt.uv = 1'b0;
            s_nxt.flt.ov1 = 1'b0;
            s_nxt.strap_vld = 1'b0;
            s_nxt.strap_cls = '0;
            s_nxt.cfg = strap_decode(3'h0);
        end
        if (!s_r.s2.por_ok) begin
            s_nxt.flt = '0;
            s_nxt.dis = 1'b0;
            s_nxt.strap_vld = 1'b0;
            s_nxt.strap_cls = '0;
            s_nxt.cfg = strap_decode(3'h0);
        end
        // a latched absolute overvoltage holds FAULT until the supply resets
        if ((!enabled && s_nxt.flt.ov2 == 1'b0) ||
                (!s_r.s2.en && s_nxt.flt == '0)) begin
            s_nxt.st = S_OFF;
        end
        if (s_nxt.st != S_SOFT && s_nxt.st != S_RUN) begin
            s_nxt.oc_cnt = '0;
            s_nxt.uv_cnt = '0;
            s_nxt.ov1_cnt = '0;
        end

        // ==========================================
        // register port; a hardware set beats a write-one clear
        s_nxt.rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                IRQ_STATUS_OFS: s_nxt.status = s_r.status & ~reg_wdata[5:0];
                IRQ_MASK_OFS: s_nxt.mask = reg_wdata[5:0];
                CTRL_OFS: s_nxt.run_allow = reg_wdata[0];
                default: begin
                end
            endcase
        end
        s_nxt.status = s_nxt.status | ev;
        if (reg_rd) begin
            case (reg_addr)
                IRQ_STATUS_OFS: s_nxt.rdata = {2'h0, s_r.status};
                IRQ_MASK_OFS: s_nxt.rdata = {2'h0, s_r.mask};
                CTRL_OFS: s_nxt.rdata = {7'h00, s_r.run_allow};
                FAULT_STATE_OFS: s_nxt.rdata = {s_r.strap_vld, s_r.pwr_good,
                                                s_r.dis, s_r.flt};
                STRAP_OFS: s_nxt.rdata = {4'h0, s_r.cfg.osr_en,
                                          s_r.strap_cls};
                default: s_nxt.rdata = '0;
            endcase
        end

        // outputs registered from the settled next state
        s_nxt.pwr_good = (s_nxt.st == S_RUN) && (s_nxt.flt == '0);
        s_nxt.gate.ls_on = s_nxt.dis;
        s_nxt.gate.hs_allow = !s_nxt.dis && s_nxt.flt == '0 &&
            (s_nxt.st == S_SOFT || s_nxt.st == S_RUN);
        s_nxt.gate.tristate = !s_nxt.gate.hs_allow && !s_nxt.dis;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.run_allow <= CTRL_RUN_RST;
            s_r.mask <= IRQ_MASK_RST;
            // switches leave reset tri-stated, never low-side on
            s_r.gate.tristate <= 1'b1;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign irq = |(s_r.status & s_r.mask);
    assign gate = s_r.gate;
    assign power_good_output = s_r.pwr_good;
    assign soft_start_req = s_r.ss_pulse;
    assign strap_cfg = s_r.cfg;

    // ==========================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    oc_qualify_a: assert property (
        clk_en && s_r.s2.cmp.oc && s_r.oc_cnt == OC_LIM &&
        s_r.s2.en && s_r.s2.por_ok &&
        (s_r.st == S_SOFT || s_r.st == S_RUN) |=> s_r.flt.oc
    ) else $error("overcurrent not latched at qualification end");
    oc_restart_a: assert property (
        clk_en && !s_r.s2.cmp.oc |=> s_r.oc_cnt == '0
    ) else $error("overcurrent timer kept counting after drop");
    strap_hold_a: assert property (
        s_r.strap_vld && $past(s_r.strap_vld) |-> $stable(s_r.strap_cls)
    ) else $error("strap class changed while held");
    woc_react_a: assert property (
        clk_en && s_r.s2.cmp.woc && !s_r.s2.cmp.ov2_hi && s_r.st == S_RUN
        |=> !power_good_output && gate.tristate && !gate.hs_allow
    ) else $error("way overcurrent not acted on");
    fault_gate_a: assert property (
        s_r.flt[3:0] != '0 && !s_r.dis
        |-> gate.tristate && !gate.hs_allow && !power_good_output
    ) else $error("latched fault left switches live");
    fault_keep_a: assert property (
        clk_en && s_r.flt.uv && s_r.s2.en && s_r.s2.por_ok |=> s_r.flt.uv
    ) else $error("undervoltage fault cleared without enable or reset");
    ov2_trip_a: assert property (
        clk_en && s_r.s2.cmp.ov2_hi && s_r.s2.en && s_r.s2.por_ok
        |=> s_r.flt.ov2 && gate.ls_on && !power_good_output
    ) else $error("absolute overvoltage did not discharge");
    ov2_release_a: assert property (
        clk_en && s_r.dis && s_r.s2.cmp.ov2_lo && !s_r.s2.cmp.ov2_hi
        |=> !gate.ls_on && !gate.hs_allow
    ) else $error("discharge not released below release level");
    ov2_sticky_a: assert property (
        s_r.flt.ov2 && s_r.s2.por_ok |=> s_r.flt.ov2
    ) else $error("absolute overvoltage cleared without supply reset");
    restart_a: assert property (
        clk_en && s_r.st == S_OFF && s_r.s2.en && s_r.s2.por_ok &&
        s_r.run_allow && s_r.flt == '0 && !s_r.s2.cmp.ov2_hi
        |=> soft_start_req ##1 !soft_start_req
    ) else $error("restart skipped soft-start");

    // ==========================================
    // qualification, strap and discharge checks
    oc_early_a: assert property (
        clk_en && !s_r.flt.oc && s_r.oc_cnt != OC_LIM |=> !s_r.flt.oc
    ) else $error("overcurrent latched before qualification end");
    uv_qualify_a: assert property (
        clk_en && s_r.s2.cmp.uv && s_r.uv_cnt == V_LIM &&
        s_r.s2.en && s_r.s2.por_ok &&
        (s_r.st == S_SOFT || s_r.st == S_RUN) |=> s_r.flt.uv
    ) else $error("undervoltage not latched at qualification end");
    ov1_qualify_a: assert property (
        clk_en && s_r.s2.cmp.ov1 && s_r.ov1_cnt == V_LIM &&
        s_r.s2.en && s_r.s2.por_ok &&
        (s_r.st == S_SOFT || s_r.st == S_RUN) |=> s_r.flt.ov1
    ) else $error("first-level overvoltage not latched at qualification end");

    uv_restart_a: assert property (
        clk_en && !s_r.s2.cmp.uv |=> s_r.uv_cnt == '0
    ) else $error("undervoltage timer kept counting after drop");
    ov1_restart_a: assert property (
        clk_en && !s_r.s2.cmp.ov1 |=> s_r.ov1_cnt == '0
    ) else $error("overvoltage timer kept counting after drop");
    strap_take_a: assert property (
        soft_start_req |-> s_r.strap_vld
    ) else $error("start-up began without a sampled strap");
    strap_drop_a: assert property (
        clk_en && !s_r.s2.en |=> !s_r.strap_vld
    ) else $error("strap kept after enable fell");

    ov2_repeat_a: assert property (
        clk_en && !s_r.dis && s_r.s2.cmp.ov2_hi && s_r.s2.en &&
        s_r.s2.por_ok |=> s_r.status[4] && gate.ls_on
    ) else $error("repeated absolute overvoltage not discharged");
    ov2_watch_a: assert property (
        clk_en && s_r.flt[3:0] != '0 && s_r.s2.cmp.ov2_hi &&
        s_r.s2.en && s_r.s2.por_ok |=> gate.ls_on && !gate.hs_allow
    ) else $error("absolute overvoltage ignored behind a latched fault");
endmodule : vr_fault_supervisor

/* File: src/vr_fault_pkg.sv */
// constants and carrier types for the regulator fault supervisor
// assumes a 40 MHz mclk and an 8-bit register port
package vr_fault_pkg;
    // ==========================================
    // clock and timing
    localparam int unsigned CLK_MHZ = 40;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned OC_QUAL_US = 120;
    localparam int unsigned OC_QUAL_CYC_DEF = OC_QUAL_US * CLK_MHZ;
    localparam int unsigned VQUAL_MS = 1;
    localparam int unsigned VQUAL_CYC_DEF = VQUAL_MS * 1000 * CLK_MHZ;
    localparam int unsigned WOC_MAX_NS = 2000;
    localparam int unsigned WOC_MAX_CYC = WOC_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned TMR_W = 16;
    // ==========================================
    // register map
    localparam int unsigned AW = 5;
    localparam int unsigned DW = 8;
    localparam logic [AW-1:0] IRQ_STATUS_OFS = 5'h00;
    localparam logic [AW-1:0] IRQ_MASK_OFS = 5'h04;
    localparam logic [AW-1:0] CTRL_OFS = 5'h08;
    localparam logic [AW-1:0] FAULT_STATE_OFS = 5'h0C;
    localparam logic [AW-1:0] STRAP_OFS = 5'h10;
    localparam logic CTRL_RUN_RST = 1'h1;
    localparam logic [5:0] IRQ_MASK_RST = 6'h00;
    // ==========================================
    // strap decode values, in microamps
    localparam logic [6:0] OC_UA_54 = 7'h36;
    localparam logic [6:0] OC_UA_60 = 7'h3C;
    localparam logic [6:0] OC_UA_62 = 7'h3E;
    localparam logic [6:0] OC_UA_68 = 7'h44;
    // ==========================================
    // carriers
    typedef struct packed {
        logic oc;
        logic woc;
        logic uv;
        logic ov1;
        logic ov2_hi;
        logic ov2_lo;
    } cmp_t;
    typedef struct packed {
        logic en;
        logic por_ok;
        cmp_t cmp;
        logic [2:0] strap;
    } pins_t;
    typedef struct packed {
        logic ov2;
        logic ov1;
        logic uv;
        logic woc;
        logic oc;
    } flt_t;
    typedef struct packed {
        logic [6:0] oc_ua;
        logic osr_en;
    } strap_cfg_t;
    typedef struct packed {
        logic hs_allow;
        logic ls_on;
        logic tristate;
    } gate_t;
    typedef enum logic [1:0] {S_OFF, S_SOFT, S_RUN, S_FAULT} sup_state_t;
endpackage : vr_fault_pkg

/* File: dv/vr_stage_model.sv */
// power stage and soft-start ramp seen behind the fault supervisor
// assumes gate levels and start pulse arrive on the same mclk
`timescale 1ns/1ps
module vr_stage_model import vr_fault_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire gate_t gate,
    input wire logic ss_req,
    input wire logic ov_hi,
    output logic ss_done,
    output logic below_rel
);
    logic [3:0] ss_c;
    logic [3:0] ls_c;
    // ==========================================
    // ramp and discharge
    // output only falls under release after the low side has pulled a while
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ss_c <= 4'h0;
            ls_c <= 4'h0;
            below_rel <= 1'b1;
        end else begin
            if (ss_req) begin
                ss_c <= 4'h1;
            end else if (gate.tristate) begin
                ss_c <= 4'h0;
            end else if (ss_c != 4'h0 && ss_c != 4'h6) begin
                ss_c <= ss_c + 4'h1;
            end
            if (!gate.ls_on) begin
                ls_c <= 4'h0;
            end else if (ls_c != 4'h4) begin
                ls_c <= ls_c + 4'h1;
            end
            if (ov_hi) begin
                below_rel <= 1'b0;
            end else if (ls_c == 4'h4) begin
                below_rel <= 1'b1;
            end
        end
    end
    assign ss_done = (ss_c == 4'h6);
endmodule : vr_stage_model

/* File: dv/tb.sv */
// self-checking bench for the regulator fault supervisor
// assumes the package and the stage model are compiled first
`timescale 1ns/1ps
module tb import vr_fault_pkg::*; ;
    localparam int OCQ = 20;
    localparam int VQ = 40;
    typedef struct packed {
        logic [2:0] cls;
        logic [6:0] ua;
        logic osr;
    } srow_t;
    srow_t rows [8] = '{
        '{3'h0, OC_UA_60, 1'h0},
        '{3'h1, OC_UA_68, 1'h0}, '{3'h2, OC_UA_62, 1'h0},
        '{3'h3, OC_UA_54, 1'h0}, '{3'h4, OC_UA_60, 1'h1},
        '{3'h5, OC_UA_68, 1'h1}, '{3'h6, OC_UA_62, 1'h1},
        '{3'h7, OC_UA_54, 1'h1}};
    logic mclk, rst_n, en, por, rd_s, wr_s, ov_hi, ss_done, below;
    logic irq, pg, ss, ce;
    logic [3:0] cv;
    logic [2:0] strap;
    logic [AW-1:0] addr;
    logic [DW-1:0] wd, rdata, d;
    gate_t gate;
    strap_cfg_t cfg;
    cmp_t cmp_w;
    int n_errors = 0;
    int compares = 0;
    int ss_cnt = 0;
    int i;
    assign cmp_w = cmp_t'({cv, ov_hi, below});
    vr_fault_supervisor #(.OC_QUAL_CYC(OCQ), .VQUAL_CYC(VQ)) dut (
        .mclk(mclk), .rst_n(rst_n), .clk_en(ce),
        .regulator_enable_input(en), .supply_por_ok(por), .cmp_in(cmp_w),
        .strap_class(strap), .soft_start_done(ss_done), .reg_addr(addr),
        .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
        .irq(irq), .gate(gate), .power_good_output(pg),
        .soft_start_req(ss), .strap_cfg(cfg));
    vr_stage_model stage (.mclk(mclk), .rst_n(rst_n), .gate(gate),
        .ss_req(ss), .ov_hi(ov_hi), .ss_done(ss_done), .below_rel(below));
    always @(posedge mclk) if (ss === 1'b1) ss_cnt <= ss_cnt + 1;
    // ==========================================
    // helpers
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task reg_write(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge mclk);
        wr_s <= 1'b1;
        addr <= a;
        wd <= v;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [AW-1:0] a, output logic [DW-1:0] v);
        @(posedge mclk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_read
    task start_up;
        int n;
        n = ss_cnt;
        @(posedge mclk);
        en <= 1'b1;
        for (int k = 0; k < 40 && pg !== 1'b1; k++) cyc(1);
        chk("power_good", pg, 1);
        chk("soft_start_pulses", ss_cnt - n, 1);
    endtask : start_up
    task stop;
        @(posedge mclk);
        en <= 1'b0;
        cyc(5);
    endtask : stop
    // a fault comparator held high for about n cycles
    task hold(input int b, input int n);
        @(posedge mclk);
        cv[b] <= 1'b1;
        cyc(n);
        @(posedge mclk);
        cv[b] <= 1'b0;
        cyc(4);
    endtask : hold
    task wrap_up;
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    // ==========================================
    // clock, watchdog, tests
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        #500000;
        n_errors++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        en = 1'b0;
        por = 1'b0;
        rd_s = 1'b0;
        wr_s = 1'b0;
        cv = 4'h0;
        ov_hi = 1'b0;
        strap = 3'h0;
        addr = '0;
        wd = '0;
        cyc(20);
        chk("gate_in_reset", gate, 3'h1);
        chk("pg_in_reset", {irq, pg, cfg}, 10'h000);
        @(posedge mclk);
        rst_n <= 1'b1;
        por <= 1'b1;
        reg_read(IRQ_MASK_OFS, d);
        chk("mask_reset", d, IRQ_MASK_RST);
        reg_read(CTRL_OFS, d);
        chk("ctrl_reset", d, CTRL_RUN_RST);
        reg_write(5'h1C, 8'hFF);
        reg_read(5'h1C, d);
        chk("unmapped", d, 8'h00);
        for (i = 0; i < 8; i++) begin
            @(posedge mclk);
            strap <= rows[i].cls;
            cyc(4);
            start_up();
            chk("strap_cfg", cfg, {rows[i].ua, rows[i].osr});
            reg_read(STRAP_OFS, d);
            chk("strap_reg", d, {4'h0, rows[i].osr, rows[i].cls});
            @(posedge mclk);
            strap <= ~rows[i].cls;
            cyc(4);
            chk("strap_held", cfg, {rows[i].ua, rows[i].osr});
            stop();
            reg_read(FAULT_STATE_OFS, d);
            chk("strap_dropped", d[7], 0);
        end
        // a software stop and restart keeps the strap taken at enable
        start_up();
        reg_write(CTRL_OFS, 8'h00);
        cyc(2);
        chk("run_stop", {gate, pg}, 4'h2);
        @(posedge mclk);
        strap <= 3'h5;
        cyc(4);
        reg_write(CTRL_OFS, 8'h01);
        start_up();
        chk("strap_kept", cfg, {OC_UA_60, 1'h0});
        stop();
        reg_write(IRQ_MASK_OFS, 8'h01);
        start_up();
        hold(3, OCQ - 3);
        chk("oc_early", pg, 1);
        hold(3, OCQ + 3);
        chk("oc_pg", pg, 0);
        chk("oc_gate", gate, 3'h1);
        chk("oc_irq", irq, 1);
        reg_write(IRQ_MASK_OFS, 8'h00);
        cyc(1);
        chk("irq_masked", irq, 0);
        reg_write(IRQ_MASK_OFS, 8'h01);
        reg_write(IRQ_STATUS_OFS, 8'h01);
        cyc(1);
        chk("irq_cleared", irq, 0);
        reg_read(FAULT_STATE_OFS, d);
        chk("oc_latched", d[0], 1);
        stop();
        reg_read(FAULT_STATE_OFS, d);
        chk("oc_cleared", d[4:0], 0);
        start_up();
        @(posedge mclk);
        cv[2] <= 1'b1;
        cyc(3);
        chk("woc_out", {gate, pg}, 4'h2);
        @(posedge mclk);
        cv[2] <= 1'b0;
        stop();
        start_up();
        for (i = 0; i < 2; i++) begin
            hold(i, VQ - 3);
            chk("v_early", pg, 1);
            hold(i, VQ + 3);
            reg_read(FAULT_STATE_OFS, d);
            chk("v_fault", d[3:2], i ? 2'h1 : 2'h2);
            chk("v_out", {gate, pg}, 4'h2);
            if (i == 0) begin
                stop();
                start_up();
            end
        end
        // the absolute level is still acted on while undervoltage is latched
        @(posedge mclk);
        ov_hi <= 1'b1;
        cyc(3);
        chk("ov2_gate", gate, 3'h2);
        @(posedge mclk);
        ov_hi <= 1'b0;
        cyc(12);
        chk("ov2_release", gate, 3'h1);
        @(posedge mclk);
        ov_hi <= 1'b1;
        cyc(3);
        chk("ov2_again", {gate, pg}, 4'h4);
        @(posedge mclk);
        ov_hi <= 1'b0;
        stop();
        reg_read(FAULT_STATE_OFS, d);
        chk("ov2_kept", d[4], 1);
        // a frozen block must not notice a supply dip
        @(posedge mclk);
        ce <= 1'b0;
        por <= 1'b0;
        cyc(4);
        @(posedge mclk);
        ce <= 1'b1;
        por <= 1'b1;
        cyc(4);
        reg_read(FAULT_STATE_OFS, d);
        chk("frozen_ov2", d[4], 1);
        @(posedge mclk);
        por <= 1'b0;
        cyc(4);
        reg_read(FAULT_STATE_OFS, d);
        chk("ov2_cleared", d[4:0], 0);
        wrap_up();
    end
endmodule : tb
